// [bench/sac_adc_cal_bench.sv]
// self-checking bench for sac_adc_cal: reset values, calibration, corrected conversions
// assumes the design under core/ and the checker compiled first
`timescale 1ns/1ps
`default_nettype none
`include "sac_defines.vh"
module sac_adc_cal_bench;
  logic clk_sys, rst, hsel, hwrite, cmpDacBelow, hreadyout, hresp, sampleHold;
  logic [1:0] htrans, calInSel;
  logic [2:0] hsize, capSel;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [11:0] dacCode;
  logic [12:0] vin, normIn;
  int failures, samples_checked, cycles, gainV;
  int capErr [7] = '{-2, -1, 0, 1, -2, 0, 1};
  sac_adc_cal sac_adc_cal_i (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .dacCode, .sampleHold, .calInSel,
    .capSel, .cmpDacBelow);
  // ------------------------------------------------------------
  // comparator stand-in: the code settles one below the input level
  // ------------------------------------------------------------
  always_comb
  begin
    if (calInSel == 2'h1)
      vin = 13'h07FE;
    else if (calInSel == 2'h2)
      vin = 13'(32'h801 + capErr[capSel]);
    else
      vin = normIn;
  end
  assign cmpDacBelow = {1'b0, dacCode} < vin;
  // ------------------------------------------------------------
  // bus and check tasks
  // ------------------------------------------------------------
  task automatic waitRdy;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
  endtask
  task automatic busOp(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    waitRdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
    rd = hrdata;
  endtask
  task automatic busRd(input logic [7:0] a);
    busOp(1'b0, a, 32'h0);
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic waitDone;
    int n;
    n = 0;
    do
    begin
      busRd(`SAC_OFS_STATUS);
      n++;
    end
    while (rd[0] !== 1'b1 && n < 400);
    if (rd[0] !== 1'b1)
    begin
      failures++;
      report_and_stop();
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic testReset;
    busOp(1'b1, 8'h40, 32'hFFFF_FFFF);
    busRd(8'h40);
    chk("unmapped", rd, 32'h0);
    busRd(`SAC_OFS_OFFSET);
    chk("offset", rd, 32'h0);
    busRd(`SAC_OFS_GAIN);
    chk("gain", rd, 32'h800);
    busRd(`SAC_OFS_CAP6);
    chk("cap6", rd, 32'h0);
    busRd(`SAC_OFS_STATUS);
    chk("status", rd, 32'h0);
    $display("test reset done");
  endtask
  task automatic testCal;
    int acc;
    busOp(1'b1, `SAC_OFS_CTRL, 32'h1);
    busRd(`SAC_OFS_STATUS);
    chk("status busy", rd, 32'h6);
    waitDone();
    chk("status", rd, 32'h1);
    busRd(`SAC_OFS_OFFSET);
    chk("offset", rd, 32'hFFFF_FFFD);
    for (int k = 0; k < 7; k++)
    begin
      acc = capErr[k];
      for (int j = 0; j < k; j++)
        acc += capErr[j] <<< (k - 1 - j);
      busRd(8'(`SAC_OFS_CAP0 + 4 * k));
      chk("cap", rd, 32'(acc));
    end
    gainV = 2048 - acc;
    busRd(`SAC_OFS_GAIN);
    chk("gain", rd, {20'h0, 12'(gainV)});
    busOp(1'b1, `SAC_OFS_STATUS, 32'h1);
    busRd(`SAC_OFS_STATUS);
    chk("status clear", rd, 32'h0);
    $display("test calibration done");
  endtask
  task automatic testConv;
    int raw;
    int res;
    logic [12:0] lv [3] = '{13'h0001, 13'h0400, 13'h1000};
    foreach (lv[i])
    begin
      normIn <= lv[i];
      busOp(1'b1, `SAC_OFS_CTRL, 32'h2);
      // a calibration start while busy must be ignored
      busOp(1'b1, `SAC_OFS_CTRL, 32'h1);
      busRd(`SAC_OFS_STATUS);
      chk("status conv busy", rd, 32'h2);
      waitDone();
      busOp(1'b1, `SAC_OFS_STATUS, 32'h1);
      raw = lv[i] - 1;
      res = ((raw + 3) * gainV) >>> 11;
      if (res > 4095)
        res = 4095;
      busRd(`SAC_OFS_RAW);
      chk("raw", rd, 32'(raw));
      busRd(`SAC_OFS_RESULT);
      chk("result", rd, 32'(res));
    end
    busRd(`SAC_OFS_OFFSET);
    chk("offset kept", rd, 32'hFFFF_FFFD);
    $display("test conversion done");
  endtask
  task automatic testMidReset;
    rst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    busRd(`SAC_OFS_OFFSET);
    chk("offset after reset", rd, 32'h0);
    busRd(`SAC_OFS_GAIN);
    chk("gain after reset", rd, 32'h800);
    busRd(`SAC_OFS_CAP0);
    chk("cap0 after reset", rd, 32'h0);
    busRd(`SAC_OFS_RESULT);
    chk("result after reset", rd, 32'h0);
    $display("test mid-run reset done");
  endtask
  // ------------------------------------------------------------
  // clock, reset, sequence, timeout
  // ------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial
  begin
    rst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    normIn = 13'h0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    testReset();
    testCal();
    testConv();
    testMidReset();
    testCal();
    report_and_stop();
  end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      report_and_stop();
    end
  end
endmodule // sac_adc_cal_bench
`default_nettype wire

// [bench/sac_adc_cal_chk.sv]
// checker for sac_adc_cal: bus response, reset state, trial timing
// assumes it is bound to the ports of the design top
`timescale 1ns/1ps
`default_nettype none
module sac_adc_cal_chk
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // front end
  input wire logic [11:0] dacCode,
  input wire logic sampleHold,
  input wire logic [1:0] calInSel,
  input wire logic [2:0] capSel
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  AST_RESET_IDLE: assert property (disable iff (1'b0) rst |=>
    dacCode == 12'h000 && !sampleHold && calInSel == 2'h0 && capSel == 3'h0 && hrdata == 32'h0)
    else $error("outputs not idle after reset");
  AST_SAMPLE_FOUR: assert property ($rose(sampleHold) |-> sampleHold [*4] ##1 !sampleHold)
    else $error("sample phase not four cycles");
  AST_MSB_FIRST: assert property ($fell(sampleHold) |-> ##[0:3] dacCode == 12'h800)
    else $error("first trial is not the top bit");
  AST_TRIAL_HOLD: assert property ($changed(dacCode) |=> $stable(dacCode) [*2])
    else $error("trial code held under three cycles");
  AST_TWELVE_ROUNDS: assert property ($fell(sampleHold) |-> ##[30:42] dacCode == 12'h000)
    else $error("trial sequence length wrong");
  AST_CAP_RANGE: assert property (calInSel == 2'h2 |-> capSel <= 3'h6)
    else $error("capacitor select out of range");
  AST_CAP_FIRST: assert property (calInSel == 2'h2 && $past(calInSel) == 2'h1 |->
    capSel == 3'h0)
    else $error("capacitor sweep does not start at the first capacitor");
  AST_CAP_STEP: assert property (calInSel == 2'h2 && $changed(capSel) |->
    capSel == $past(capSel) + 3'h1)
    else $error("capacitor sweep steps out of order");
  AST_READ_HOLD: assert property (!(hsel && htrans[1] && hready && !hwrite) |=>
    $stable(hrdata))
    else $error("read data moved without a read");
endmodule // sac_adc_cal_chk
bind sac_adc_cal sac_adc_cal_chk sac_adc_cal_chk_i (.clk_sys, .rst, .hsel, .htrans, .hwrite,
  .hready, .hrdata, .hreadyout, .hresp, .dacCode, .sampleHold, .calInSel, .capSel);
`default_nettype wire

// [core/sac_adc_cal.v]
// successive-approximation control with self-calibration and result correction, AHB-Lite slave
// assumes a comparator pin asynchronous to clk_sys and an analog front end steered by calInSel
// ------------------------------------------------------------
// How it works
// - writing the calibration start bit launches the whole calibration sequence unaided.
// - there is no calibration-failed flag; software range-checks the stored results itself.
// - the offset correction is written by hardware after the zero-input conversion, the gain correction at the end of calibration.
// - every capacitor value computed during calibration lands in its own register.
// - each conversion result has the offset subtracted and is then scaled by the gain.
// - a 12-bit code is built from one trial per bit, twelve compare rounds in all.
// - trials start at the top bit, set it, and keep it only when the DAC is below the input.
// - the accumulated error of bit k is Ek plus lower errors at binary-growing weights.
// - the conversion-complete flag is raised when a normal conversion ends and when the whole calibration sequence ends.
// ------------------------------------------------------------
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sac_defines.vh"

module sac_adc_cal
(
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // analog front end
  output reg [11:0] dacCode,
  output reg sampleHold,
  output reg [1:0] calInSel,
  output reg [2:0] capSel,
  input wire cmpDacBelow
);

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_SAMP = 5'h02;
  localparam [4:0] ST_TRIAL = 5'h04;
  localparam [4:0] ST_STORE = 5'h08;
  localparam [4:0] ST_CORR = 5'h10;

  reg [4:0] state_ff;
  reg [3:0] cnt_ff;
  reg [11:0] trial_ff;
  reg [11:0] raw_ff;
  reg [11:0] result_ff;
  reg calRun_ff;
  reg [3:0] step_ff;
  reg signed [15:0] run_ff;
  reg signed [12:0] offset_ff;
  reg [11:0] gain_ff;
  reg signed [15:0] cap_ff [0:`SAC_CAP_COUNT-1];
  reg done_ff;
  reg cmpMeta_ff;
  reg cmpSync_ff;
  reg busWr_ff;
  reg busAct_ff;
  reg [7:0] busAddr_ff;
  integer i;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ------------------------------------------------------------
  // comparator synchroniser
  // ------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      cmpMeta_ff <= 1'b0;
      cmpSync_ff <= 1'b0;
    end
    else
    begin
      cmpMeta_ff <= cmpDacBelow;
      cmpSync_ff <= cmpMeta_ff;
    end
  end

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  wire addrPhase = hsel & htrans[1] & hready;
  wire wrNow = busAct_ff & busWr_ff;
  wire calReq = wrNow && (busAddr_ff == `SAC_OFS_CTRL) && hwdata[`SAC_CTRL_CAL_BIT];
  wire convReq = wrNow && (busAddr_ff == `SAC_OFS_CTRL) && hwdata[`SAC_CTRL_CONV_BIT];
  wire doneClr = wrNow && (busAddr_ff == `SAC_OFS_STATUS) && hwdata[`SAC_STAT_DONE_BIT];
  wire idle = state_ff[0];

  // ------------------------------------------------------------
  // calibration arithmetic
  // ------------------------------------------------------------
  wire signed [12:0] err = $signed({1'b0, raw_ff}) - $signed(`SAC_MID_CODE);
  wire signed [15:0] errWide = {{3{err[12]}}, err};
  wire signed [15:0] accErr = errWide + run_ff;
  wire [2:0] capIdx = step_ff[2:0] - 3'h1;
  wire lastStep = (step_ff == `SAC_CAP_COUNT);

  // ------------------------------------------------------------
  // correction arithmetic
  // ------------------------------------------------------------
  wire signed [13:0] diff = $signed({2'b00, raw_ff}) - $signed({offset_ff[12], offset_ff});
  wire signed [26:0] prod = diff * $signed({1'b0, gain_ff});
  wire signed [26:0] scaled = prod >>> `SAC_GAIN_SHIFT;
  reg [11:0] nxt_result;
  always @*
  begin
    if (scaled < 0)
      nxt_result = 12'h000;
    else if (scaled > $signed({15'h0000, `SAC_CODE_MAX}))
      nxt_result = `SAC_CODE_MAX;
    else
      nxt_result = scaled[11:0];
  end

  // ------------------------------------------------------------
  // conversion and calibration sequencer
  // ------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      trial_ff <= 12'h000;
      dacCode <= 12'h000;
      raw_ff <= 12'h000;
      result_ff <= 12'h000;
      sampleHold <= 1'b0;
      calInSel <= `SAC_SEL_NORMAL;
      capSel <= 3'h0;
      calRun_ff <= 1'b0;
      step_ff <= 4'h0;
      run_ff <= 16'h0000;
      offset_ff <= `SAC_RST_OFFSET;
      gain_ff <= `SAC_RST_GAIN;
      for (i = 0; i < `SAC_CAP_COUNT; i = i + 1)
        cap_ff[i] <= 16'h0000;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (calReq)
          begin
            calRun_ff <= 1'b1;
            step_ff <= 4'h0;
            run_ff <= 16'h0000;
            calInSel <= `SAC_SEL_ZERO;
            sampleHold <= 1'b1;
            cnt_ff <= `SAC_SAMPLE_CYC;
            state_ff <= ST_SAMP;
          end
          else if (convReq)
          begin
            calInSel <= `SAC_SEL_NORMAL;
            sampleHold <= 1'b1;
            cnt_ff <= `SAC_SAMPLE_CYC;
            state_ff <= ST_SAMP;
          end
        end
        ST_SAMP:
        begin
          if (cnt_ff == 4'h1)
          begin
            sampleHold <= 1'b0;
            trial_ff <= 12'h800;
            dacCode <= 12'h800;
            cnt_ff <= `SAC_SETTLE_CYC;
            state_ff <= ST_TRIAL;
          end
          else
            cnt_ff <= cnt_ff - 4'h1;
        end
        ST_TRIAL:
        begin
          if (cnt_ff == 4'h1)
          begin
            cnt_ff <= `SAC_SETTLE_CYC;
            // keep the bit only when the dac sits below the input
            if (trial_ff[0])
            begin
              raw_ff <= cmpSync_ff ? dacCode : (dacCode & ~trial_ff);
              dacCode <= 12'h000;
              state_ff <= calRun_ff ? ST_STORE : ST_CORR;
            end
            else
            begin
              dacCode <= (cmpSync_ff ? dacCode : (dacCode & ~trial_ff)) | (trial_ff >> 1);
              trial_ff <= trial_ff >> 1;
            end
          end
          else
            cnt_ff <= cnt_ff - 4'h1;
        end
        ST_STORE:
        begin
          if (step_ff == 4'h0)
            offset_ff <= err;
          else
          begin
            cap_ff[capIdx] <= accErr;
            run_ff <= (run_ff <<< 1) + errWide;
          end
          if (lastStep)
          begin
            gain_ff <= `SAC_GAIN_UNITY - accErr[11:0];
            calRun_ff <= 1'b0;
            calInSel <= `SAC_SEL_NORMAL;
            capSel <= 3'h0;
            state_ff <= ST_IDLE;
          end
          else
          begin
            capSel <= step_ff[2:0];
            calInSel <= `SAC_SEL_CAP;
            step_ff <= step_ff + 4'h1;
            sampleHold <= 1'b1;
            cnt_ff <= `SAC_SAMPLE_CYC;
            state_ff <= ST_SAMP;
          end
        end
        ST_CORR:
        begin
          result_ff <= nxt_result;
          state_ff <= ST_IDLE;
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // completion flag, set wins over clear
  // ------------------------------------------------------------
  wire doneSet = (state_ff == ST_CORR) || ((state_ff == ST_STORE) && lastStep);
  always @(posedge clk_sys)
  begin
    if (rst)
      done_ff <= 1'b0;
    else if (doneSet)
      done_ff <= 1'b1;
    else if (doneClr)
      done_ff <= 1'b0;
  end

  // ------------------------------------------------------------
  // ahb data phase tracking and read data
  // ------------------------------------------------------------
  reg [31:0] nxt_rdata;
  reg [7:0] rdAddr;
  always @*
  begin
    rdAddr = {haddr[7:2], 2'b00};
    nxt_rdata = 32'h00000000;
    if (rdAddr == `SAC_OFS_STATUS)
      nxt_rdata = {29'h0, calRun_ff, ~idle, done_ff};
    else if (rdAddr == `SAC_OFS_RESULT)
      nxt_rdata = {20'h00000, result_ff};
    else if (rdAddr == `SAC_OFS_RAW)
      nxt_rdata = {20'h00000, raw_ff};
    else if (rdAddr == `SAC_OFS_OFFSET)
      nxt_rdata = {{19{offset_ff[12]}}, offset_ff};
    else if (rdAddr == `SAC_OFS_GAIN)
      nxt_rdata = {20'h00000, gain_ff};
    else if (rdAddr >= `SAC_OFS_CAP0 && rdAddr <= `SAC_OFS_CAP6)
      nxt_rdata = {{16{cap_ff[rdAddr[4:2] - 3'h6][15]}}, cap_ff[rdAddr[4:2] - 3'h6]};
  end

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      busAct_ff <= 1'b0;
      busWr_ff <= 1'b0;
      busAddr_ff <= 8'h00;
      hrdata <= 32'h00000000;
    end
    else
    begin
      busAct_ff <= addrPhase;
      busWr_ff <= hwrite;
      busAddr_ff <= {haddr[7:2], 2'b00};
      if (addrPhase && !hwrite)
        hrdata <= nxt_rdata;
    end
  end

endmodule // sac_adc_cal
`default_nettype wire

// [core/sac_defines.vh]
// constants for the converter control block: register offsets, fields, reset values, timing
// assumes byte addresses on a 32-bit bus with one register per aligned word
`ifndef SAC_DEFINES_VH
`define SAC_DEFINES_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define SAC_OFS_CTRL 8'h00
`define SAC_OFS_STATUS 8'h04
`define SAC_OFS_RESULT 8'h08
`define SAC_OFS_RAW 8'h0C
`define SAC_OFS_OFFSET 8'h10
`define SAC_OFS_GAIN 8'h14
`define SAC_OFS_CAP0 8'h18
`define SAC_OFS_CAP6 8'h30

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define SAC_CTRL_CAL_BIT 0
`define SAC_CTRL_CONV_BIT 1
`define SAC_STAT_DONE_BIT 0
`define SAC_STAT_BUSY_BIT 1
`define SAC_STAT_CAL_BIT 2

// ------------------------------------------------------------
// reset values and arithmetic constants
// ------------------------------------------------------------
`define SAC_RST_OFFSET 13'h0000
`define SAC_RST_GAIN 12'h800
`define SAC_GAIN_UNITY 12'h800
`define SAC_GAIN_SHIFT 11
`define SAC_MID_CODE 13'h0800
`define SAC_CODE_MAX 12'hFFF
`define SAC_CAP_COUNT 7

// ------------------------------------------------------------
// front-end input selection
// ------------------------------------------------------------
`define SAC_SEL_NORMAL 2'h0
`define SAC_SEL_ZERO 2'h1
`define SAC_SEL_CAP 2'h2

// ------------------------------------------------------------
// timing in clk_sys cycles
// ------------------------------------------------------------
`define SAC_SAMPLE_CYC 4'h4
`define SAC_SETTLE_CYC 4'h3

`endif
